/* File: pemc_pkg.sv */
// Package for the event interrupt and operating mode controller.
// Assumes one 40 MHz system clock; all numbers used by the design live here.
package pemc_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DEGLITCH_MS = 5;
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_MS * CLK_HZ) / 1000;
  localparam int unsigned DGL_W = 18;

  localparam int unsigned N_SUPPLY = 8;
  localparam int unsigned N_EVT = 14;
  localparam int unsigned N_GROUP = 4;

  // Supply index layout.
  localparam int unsigned SUP_BUCK_A = 0;
  localparam int unsigned SUP_BUCK_B = 1;
  localparam int unsigned SUP_BOOST_LED = 2;
  localparam int unsigned SUP_LINREG_1 = 3;

  // Event index layout.
  localparam int unsigned EV_THERMAL = 0;
  localparam int unsigned EV_GPIO1 = 1;
  localparam int unsigned EV_GPIO2 = 2;
  localparam int unsigned EV_ADC_EOC = 3;
  localparam int unsigned EV_ADC_RANGE = 4;
  localparam int unsigned EV_ADC_RLOAD = 5;
  localparam int unsigned EV_CHG_STATE = 6;
  localparam int unsigned EV_DYN_POWER_PATH_MGMT = 7;
  localparam int unsigned EV_SUSPEND = 8;
  localparam int unsigned EV_FOLDBACK = 9;
  localparam int unsigned EV_AC_DET = 10;
  localparam int unsigned EV_USB_DET = 11;
  localparam int unsigned EV_IN_OVP = 12;
  localparam int unsigned EV_SRC_SW = 13;

  // Group index layout for the group mask port.
  localparam int unsigned GRP_SYS = 0;
  localparam int unsigned GRP_ADC = 1;
  localparam int unsigned GRP_CHG = 2;
  localparam int unsigned GRP_INP = 3;

  // Reset control register bit positions.
  localparam int unsigned RCTL_SOFT_RST = 0;
  localparam int unsigned RCTL_SLEEP = 6;
  localparam int unsigned RCTL_W = 8;

  localparam logic [N_EVT-1:0] EVT_ZERO = 14'h0000;
  localparam logic [N_SUPPLY-1:0] SUP_ZERO = 8'h00;

  typedef enum logic [1:0] {
    PEMC_CHG_OFF,
    PEMC_CHG_PRE,
    PEMC_CHG_FAST,
    PEMC_CHG_DONE
  } pemc_chg_t;

  // Charger and input power status levels from the analog side.
  typedef struct packed {
    pemc_chg_t chg_state;
    logic dyn_power_path_mgmt;
    logic suspend;
    logic foldback;
    logic ac_det;
    logic usb_det;
    logic in_ovp;
    logic src_usb;
  } pemc_status_t;

  localparam pemc_status_t STATUS_RST = '{PEMC_CHG_OFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  // Event pulses from the converter engine.
  typedef struct packed {
    logic eoc;
    logic range;
    logic rload;
  } pemc_adc_t;

  typedef enum logic [2:0] {
    PEMC_ST_RESET,
    PEMC_ST_PGCHECK,
    PEMC_ST_NORMAL,
    PEMC_ST_SLEEP,
    PEMC_ST_HWHOLD
  } pemc_state_t;

endpackage : pemc_pkg

/* File: pemc_deglitch.sv */
// Deglitch filter for the active-low hardware reset input.
// Assumes the input is already synchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
module pemc_deglitch import pemc_pkg::*; #(
  parameter int unsigned CYCLES = DEGLITCH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_n,
  output logic held,
  output logic release_pulse
);

  logic [DGL_W-1:0] cnt;
  logic [DGL_W-1:0] next_cnt;
  logic next_held;
  logic next_release;

  always_comb begin
    next_cnt = cnt;
    next_held = held;
    next_release = 1'b0;
    if (!in_n) begin
      if (cnt < DGL_W'(CYCLES)) begin
        next_cnt = cnt + 1'b1;
      end else begin
        next_held = 1'b1;
      end
    end else begin
      next_cnt = '0;
      next_held = 1'b0;
      next_release = held;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= '0;
      held <= 1'b0;
      release_pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      held <= next_held;
      release_pulse <= next_release;
    end
  end

endmodule : pemc_deglitch
`default_nettype wire

/* File: pemc_top.sv */
// Event collection, interrupt request and operating mode control.
// Assumes synchronous inputs, an external reset-timer capacitor comparator and an external INT pull-up.
// How it works
// - Eight supply faults, own masks, blanked at power-up.
// - System group: thermal, GPIO1/2 when configured.
// - Converter group: end, out of range, load.
// - Charger state and flag changes raise events.
// - Input detect, overvoltage, source switch changes raise events.
// - Non-fault sources: individual masks plus group masks.
// - Supply fault means output below ninety percent.
// - Boost fault means output overvoltage reached.
// - Unmasked fault: sleep or new power-up.
// - Thermal fault forces sleep, never masked.
// - Thermal sleep exits after input and battery cycling.
// - Hardware reset input low gives host reset.
// - Software reset bit gives host reset pulse.
// - Reset pulse width set by external capacitor.
// - Reset low: requests ignored, interrupt driver off.
// - Soft reset bit 0, sleep bit 6.
// - Hardware reset deglitched; release starts reset mode.
`timescale 1ns/100ps
`default_nettype none
module pemc_top import pemc_pkg::*; #(
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [N_SUPPLY-1:0] SUPPLY_LOW,
  input wire logic BOOST_OVP,
  input wire logic [N_SUPPLY-1:0] PG_MASK,
  input wire logic THERMAL_FAULT,
  input wire logic [1:0] GPIO_IN,
  input wire logic [1:0] GPIO_IRQ_CFG,
  input wire pemc_adc_t ADC_EVT,
  input wire pemc_status_t PWR_STATUS,
  input wire logic [N_EVT-1:0] EVT_MASK,
  input wire logic [N_GROUP-1:0] GROUP_MASK,
  input wire logic [N_EVT-1:0] EVT_CLEAR,
  input wire logic [N_SUPPLY-1:0] PG_CLEAR,
  input wire logic RST_CTRL_WR,
  input wire logic [RCTL_W-1:0] RST_CTRL,
  input wire logic hw_reset_in_n,
  input wire logic RST_TIMER_DONE,
  input wire logic IN_PWR,
  input wire logic BAT_PWR,
  output logic host_reset_out_n,
  output logic RST_TIMER_RUN,
  output logic INT_O,
  output logic INT_OE,
  output logic [N_EVT-1:0] EVT_PEND,
  output logic [N_SUPPLY-1:0] PG_PEND,
  output logic [N_SUPPLY-1:0] PG_FAULT_STAT,
  output pemc_state_t MODE,
  output logic SLEEP_THERMAL
);

  // Builds the per-supply fault vector; the boost slot uses its overvoltage flag.
  function automatic logic [N_SUPPLY-1:0] supply_fault(input logic [N_SUPPLY-1:0] low, input logic ovp);
    logic [N_SUPPLY-1:0] f;
    f = low;
    f[SUP_BOOST_LED] = ovp;
    return f;
  endfunction : supply_fault

  // Expands the group mask into one bit per event.
  function automatic logic [N_EVT-1:0] group_expand(input logic [N_GROUP-1:0] g);
    logic [N_EVT-1:0] e;
    e = EVT_ZERO;
    e[EV_THERMAL] = g[GRP_SYS];
    e[EV_GPIO1] = g[GRP_SYS];
    e[EV_GPIO2] = g[GRP_SYS];
    e[EV_ADC_EOC] = g[GRP_ADC];
    e[EV_ADC_RANGE] = g[GRP_ADC];
    e[EV_ADC_RLOAD] = g[GRP_ADC];
    e[EV_CHG_STATE] = g[GRP_CHG];
    e[EV_DYN_POWER_PATH_MGMT] = g[GRP_CHG];
    e[EV_SUSPEND] = g[GRP_CHG];
    e[EV_FOLDBACK] = g[GRP_CHG];
    e[EV_AC_DET] = g[GRP_INP];
    e[EV_USB_DET] = g[GRP_INP];
    e[EV_IN_OVP] = g[GRP_INP];
    e[EV_SRC_SW] = g[GRP_INP];
    return e;
  endfunction : group_expand

  logic hw_held;
  logic hw_release;

  pemc_deglitch #(
    .CYCLES(DEGLITCH_CYCLES)
  ) u_deglitch (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .in_n(hw_reset_in_n),
    .held(hw_held),
    .release_pulse(hw_release)
  );

  // Edge detection state.
  pemc_status_t prev_status;
  logic prev_thermal;
  logic [1:0] prev_gpio;
  pemc_adc_t prev_adc;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      prev_status <= STATUS_RST;
      prev_thermal <= 1'b0;
      prev_gpio <= 2'h0;
      prev_adc <= '{1'b0, 1'b0, 1'b0};
    end else begin
      prev_status <= PWR_STATUS;
      prev_thermal <= THERMAL_FAULT;
      prev_gpio <= GPIO_IN;
      prev_adc <= ADC_EVT;
    end
  end

  logic thermal_rise;
  logic [N_EVT-1:0] evt_raw;
  logic [N_SUPPLY-1:0] pg_raw;
  logic pg_trip;
  logic soft_rst;
  logic soft_sleep;

  always_comb begin
    thermal_rise = THERMAL_FAULT && !prev_thermal;
    evt_raw = EVT_ZERO;
    evt_raw[EV_THERMAL] = thermal_rise;
    evt_raw[EV_GPIO1] = GPIO_IRQ_CFG[0] && GPIO_IN[0] && !prev_gpio[0];
    evt_raw[EV_GPIO2] = GPIO_IRQ_CFG[1] && GPIO_IN[1] && !prev_gpio[1];
    evt_raw[EV_ADC_EOC] = ADC_EVT.eoc && !prev_adc.eoc;
    evt_raw[EV_ADC_RANGE] = ADC_EVT.range && !prev_adc.range;
    evt_raw[EV_ADC_RLOAD] = ADC_EVT.rload && !prev_adc.rload;
    evt_raw[EV_CHG_STATE] = PWR_STATUS.chg_state != prev_status.chg_state;
    evt_raw[EV_DYN_POWER_PATH_MGMT] = PWR_STATUS.dyn_power_path_mgmt ^ prev_status.dyn_power_path_mgmt;
    evt_raw[EV_SUSPEND] = PWR_STATUS.suspend ^ prev_status.suspend;
    evt_raw[EV_FOLDBACK] = PWR_STATUS.foldback ^ prev_status.foldback;
    evt_raw[EV_AC_DET] = PWR_STATUS.ac_det ^ prev_status.ac_det;
    evt_raw[EV_USB_DET] = PWR_STATUS.usb_det ^ prev_status.usb_det;
    evt_raw[EV_IN_OVP] = PWR_STATUS.in_ovp ^ prev_status.in_ovp;
    evt_raw[EV_SRC_SW] = PWR_STATUS.src_usb ^ prev_status.src_usb;
    // Comparator outputs are blanked while the host reset is low.
    pg_raw = host_reset_out_n ? supply_fault(SUPPLY_LOW, BOOST_OVP) : SUP_ZERO;
    pg_trip = |(pg_raw & ~PG_MASK);
    soft_rst = RST_CTRL_WR && RST_CTRL[RCTL_SOFT_RST];
    soft_sleep = RST_CTRL_WR && RST_CTRL[RCTL_SLEEP];
  end

  // Mode controller.
  pemc_state_t state;
  pemc_state_t next_state;
  logic next_sleep_thermal;
  logic pwr_gone;
  logic next_pwr_gone;
  logic next_reset_n;

  always_comb begin
    next_state = state;
    next_sleep_thermal = SLEEP_THERMAL;
    next_pwr_gone = pwr_gone;
    if (thermal_rise && state != PEMC_ST_SLEEP) begin
      next_state = PEMC_ST_SLEEP;
      next_sleep_thermal = 1'b1;
      next_pwr_gone = 1'b0;
    end else begin
      case (state)
        PEMC_ST_RESET: begin
          if (RST_TIMER_DONE) begin
            next_state = PEMC_ST_PGCHECK;
          end
        end
        PEMC_ST_PGCHECK: begin
          if (pg_trip) begin
            next_state = PEMC_ST_SLEEP;
            next_sleep_thermal = 1'b0;
            next_pwr_gone = 1'b0;
          end else begin
            next_state = PEMC_ST_NORMAL;
          end
        end
        PEMC_ST_NORMAL: begin
          if (hw_held) begin
            next_state = PEMC_ST_HWHOLD;
          end else if (pg_trip) begin
            next_state = PEMC_ST_RESET;
          end else if (soft_rst) begin
            next_state = PEMC_ST_RESET;
          end else if (soft_sleep) begin
            next_state = PEMC_ST_SLEEP;
            next_sleep_thermal = 1'b0;
            next_pwr_gone = 1'b0;
          end
        end
        PEMC_ST_HWHOLD: begin
          if (hw_release) begin
            next_state = PEMC_ST_RESET;
          end
        end
        PEMC_ST_SLEEP: begin
          if (!pwr_gone) begin
            // Thermal sleep needs both supplies gone before it can end.
            next_pwr_gone = SLEEP_THERMAL ? (!IN_PWR && !BAT_PWR) : !IN_PWR;
          end else if (IN_PWR) begin
            next_state = PEMC_ST_RESET;
            next_sleep_thermal = 1'b0;
            next_pwr_gone = 1'b0;
          end
        end
        default: begin
          next_state = PEMC_ST_RESET;
        end
      endcase
    end
    next_reset_n = (next_state == PEMC_ST_PGCHECK) || (next_state == PEMC_ST_NORMAL);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state <= PEMC_ST_RESET;
      SLEEP_THERMAL <= 1'b0;
      pwr_gone <= 1'b0;
      host_reset_out_n <= 1'b0;
    end else begin
      state <= next_state;
      SLEEP_THERMAL <= next_sleep_thermal;
      pwr_gone <= next_pwr_gone;
      host_reset_out_n <= next_reset_n;
    end
  end

  assign MODE = state;
  assign RST_TIMER_RUN = (state == PEMC_ST_RESET);
  assign INT_O = 1'b0;

  // Pending events; a new event wins over a clear in the same cycle.
  logic [N_EVT-1:0] next_evt_pend;
  logic [N_SUPPLY-1:0] next_pg_pend;
  logic [N_EVT-1:0] evt_en;
  logic next_int_oe;

  always_comb begin
    next_evt_pend = EVT_PEND & ~EVT_CLEAR;
    next_pg_pend = PG_PEND & ~PG_CLEAR;
    if (host_reset_out_n) begin
      next_evt_pend = next_evt_pend | evt_raw;
      next_pg_pend = next_pg_pend | pg_raw;
    end
    evt_en = ~EVT_MASK & ~group_expand(GROUP_MASK);
    next_int_oe = next_reset_n && ((|(next_evt_pend & evt_en)) || (|(next_pg_pend & ~PG_MASK)));
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      EVT_PEND <= EVT_ZERO;
      PG_PEND <= SUP_ZERO;
      PG_FAULT_STAT <= SUP_ZERO;
      INT_OE <= 1'b0;
    end else begin
      EVT_PEND <= next_evt_pend;
      PG_PEND <= next_pg_pend;
      PG_FAULT_STAT <= supply_fault(SUPPLY_LOW, BOOST_OVP);
      INT_OE <= next_int_oe;
    end
  end

  a_int_off_reset: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !host_reset_out_n |-> !INT_OE) else $error("interrupt driven while host reset low");
  a_thermal_to_sleep: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (THERMAL_FAULT && !prev_thermal && state != PEMC_ST_SLEEP) |=> (state == PEMC_ST_SLEEP && SLEEP_THERMAL))
    else $error("thermal fault did not force sleep");
  a_thermal_stays: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (state == PEMC_ST_SLEEP && SLEEP_THERMAL && !pwr_gone && BAT_PWR) |=> (state == PEMC_ST_SLEEP))
    else $error("thermal sleep left without power cycling");
  a_hw_release_reset: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (state == PEMC_ST_HWHOLD && hw_release && !thermal_rise) |=> (state == PEMC_ST_RESET) ##1 !host_reset_out_n)
    else $error("hardware reset release did not start reset mode");
  a_soft_reset: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (state == PEMC_ST_NORMAL && RST_CTRL_WR && RST_CTRL[RCTL_SOFT_RST] && !hw_held && !thermal_rise)
    |=> (!host_reset_out_n && RST_TIMER_RUN)) else $error("software reset gave no host reset");
  a_timer_width: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (state == PEMC_ST_RESET && !RST_TIMER_DONE && !thermal_rise) |=> (state == PEMC_ST_RESET))
    else $error("reset ended before timer expiry");
  a_pgcheck_sleep: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (state == PEMC_ST_PGCHECK && pg_trip && !thermal_rise) |=> (state == PEMC_ST_SLEEP))
    else $error("power-good fault in check did not set sleep");
  a_set_over_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (host_reset_out_n && evt_raw[EV_CHG_STATE] && EVT_CLEAR[EV_CHG_STATE]) |=> EVT_PEND[EV_CHG_STATE])
    else $error("charger event lost against clear");
  a_group_mask_off: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    ((&GROUP_MASK) && (&PG_MASK)) |=> !INT_OE) else $error("interrupt despite all masks");
  a_pend_drives_int: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (host_reset_out_n && $past(host_reset_out_n) && |(EVT_PEND & ~$past(EVT_MASK) & ~group_expand($past(GROUP_MASK))))
    |-> INT_OE) else $error("pending unmasked event without interrupt");

  c_normal: cover property (@(posedge CLK_SYS) disable iff (!RST_B) state == PEMC_ST_NORMAL);
  c_thermal_sleep: cover property (@(posedge CLK_SYS) disable iff (!RST_B) state == PEMC_ST_SLEEP && SLEEP_THERMAL);
  c_hw_reset: cover property (@(posedge CLK_SYS) disable iff (!RST_B) state == PEMC_ST_HWHOLD ##1 state == PEMC_ST_RESET);
  c_int: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $rose(INT_OE));

endmodule : pemc_top
`default_nettype wire

/* File: pemc_host_model.sv */
// Host-side partner: the reset-timer capacitor and the pulled-up interrupt line.
// Assumes the device pulls the line low only through its open-drain enable.
`timescale 1ns/100ps
`default_nettype none
module pemc_host_model #(
  parameter int unsigned TCAP = 12
) (
  input wire logic clk,
  input wire logic timer_run,
  input wire logic int_o,
  input wire logic int_oe,
  output logic timer_done,
  output wire logic int_line
);
  int unsigned cnt = 0;

  // The capacitor charges only while the timer runs and discharges at once otherwise.
  always @(posedge clk) begin
    cnt <= timer_run ? cnt + 1 : 0;
  end
  assign timer_done = timer_run && cnt >= TCAP;
  // The pull-up sets the level whenever the open-drain driver is off.
  assign int_line = int_oe ? int_o : 1'b1;
endmodule : pemc_host_model
`default_nettype wire

/* File: pemc_top_test.sv */
// Self-checking testbench for the event interrupt and operating mode controller.
// Assumes the host model for the reset capacitor and the pulled-up interrupt line.
`timescale 1ns/100ps
`default_nettype none
module pemc_top_test import pemc_pkg::*; ();
  localparam int unsigned DGL = 8;
  localparam int unsigned TCAP = 12;
  logic clk_sys, rst_b, boost_ovp, thermal, rst_ctrl_wr, hw_rst_n, in_pwr, bat_pwr;
  logic [N_SUPPLY-1:0] supply_low, pg_mask, pg_clear, pg_pend, pg_stat;
  logic [1:0] gpio_in, gpio_cfg;
  pemc_adc_t adc_evt;
  pemc_status_t pwr_status;
  logic [N_EVT-1:0] evt_mask, evt_clear, evt_pend;
  logic [N_GROUP-1:0] group_mask;
  logic [RCTL_W-1:0] rst_ctrl;
  logic timer_done, host_rst_n, timer_run, int_o, int_oe, sleep_th;
  pemc_state_t mode;
  wire int_line;
  int fail_count = 0;
  int n_compared = 0;

  pemc_top #(.DEGLITCH_CYCLES(DGL)) u_pemc_top (.CLK_SYS(clk_sys), .RST_B(rst_b), .SUPPLY_LOW(supply_low),
    .BOOST_OVP(boost_ovp), .PG_MASK(pg_mask), .THERMAL_FAULT(thermal), .GPIO_IN(gpio_in), .GPIO_IRQ_CFG(gpio_cfg),
    .ADC_EVT(adc_evt), .PWR_STATUS(pwr_status), .EVT_MASK(evt_mask), .GROUP_MASK(group_mask),
    .EVT_CLEAR(evt_clear), .PG_CLEAR(pg_clear), .RST_CTRL_WR(rst_ctrl_wr), .RST_CTRL(rst_ctrl),
    .hw_reset_in_n(hw_rst_n), .RST_TIMER_DONE(timer_done), .IN_PWR(in_pwr), .BAT_PWR(bat_pwr),
    .host_reset_out_n(host_rst_n), .RST_TIMER_RUN(timer_run), .INT_O(int_o), .INT_OE(int_oe),
    .EVT_PEND(evt_pend), .PG_PEND(pg_pend), .PG_FAULT_STAT(pg_stat), .MODE(mode), .SLEEP_THERMAL(sleep_th));

  pemc_host_model #(.TCAP(TCAP)) u_pemc_host_model (.clk(clk_sys), .timer_run(timer_run), .int_o(int_o),
    .int_oe(int_oe), .timer_done(timer_done), .int_line(int_line));

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wait_mode(pemc_state_t m, int lim);
    for (int i = 0; i < lim && mode !== m; i++) begin
      cyc(1);
    end
    check("MODE", m, mode);
  endtask : wait_mode

  // Checks one latched event and its interrupt level, then clears it.
  task automatic ev_hit(int idx, logic int_exp);
    cyc(2);
    check("EVT_PEND", 32'h1 << idx, evt_pend);
    check("INT_OE", int_exp, int_oe);
    check("INT_LINE", !int_exp, int_line);
    @(posedge clk_sys);
    evt_clear <= 14'h0001 << idx;
    @(posedge clk_sys);
    evt_clear <= '0;
    cyc(2);
    check("EVT_PEND", 0, evt_pend);
    check("INT_OE", 0, int_oe);
  endtask : ev_hit

  task automatic wr_ctrl(logic [7:0] v);
    @(posedge clk_sys);
    rst_ctrl_wr <= 1'b1;
    rst_ctrl <= v;
    @(posedge clk_sys);
    rst_ctrl_wr <= 1'b0;
    #1;
  endtask : wr_ctrl

  task automatic pwr_cycle(logic bat_off);
    @(posedge clk_sys);
    in_pwr <= 1'b0;
    bat_pwr <= !bat_off;
    cyc(3);
    @(posedge clk_sys);
    in_pwr <= 1'b1;
    bat_pwr <= 1'b1;
    wait_mode(PEMC_ST_NORMAL, 60);
  endtask : pwr_cycle

  task automatic t_reset();
    cyc(1);
    check("MODE", PEMC_ST_RESET, mode);
    check("RESET_OUT", 0, host_rst_n);
    check("INT_OE", 0, int_oe);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_mode(PEMC_ST_NORMAL, 60);
    check("RESET_OUT", 1, host_rst_n);
  endtask : t_reset

  task automatic t_sys();
    @(posedge clk_sys);
    gpio_in <= 2'b01;
    cyc(3);
    check("EVT_PEND", 0, evt_pend);
    @(posedge clk_sys);
    gpio_in <= 2'b00;
    gpio_cfg <= 2'b11;
    @(posedge clk_sys);
    gpio_in <= 2'b10;
    ev_hit(EV_GPIO2, 1'b1);
    @(posedge clk_sys);
    group_mask[GRP_SYS] <= 1'b1;
    gpio_in <= 2'b11;
    ev_hit(EV_GPIO1, 1'b0);
    @(posedge clk_sys);
    gpio_in <= 2'b00;
    group_mask <= '0;
  endtask : t_sys

  task automatic t_adc();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      evt_mask[EV_ADC_RLOAD] <= (i == 2);
      adc_evt <= pemc_adc_t'(3'h4 >> i);
      @(posedge clk_sys);
      adc_evt <= '0;
      ev_hit(EV_ADC_EOC + i, i != 2);
    end
  endtask : t_adc

  task automatic t_pwr();
    for (int i = 1; i < 4; i++) begin
      @(posedge clk_sys);
      pwr_status.chg_state <= pemc_chg_t'(i);
      ev_hit(EV_CHG_STATE, 1'b1);
    end
    // Each flag is raised and then dropped, so both directions are seen.
    for (int b = 0; b < 14; b++) begin
      @(posedge clk_sys);
      pwr_status[b % 7] <= !pwr_status[b % 7];
      ev_hit(EV_SRC_SW - b % 7, 1'b1);
    end
  endtask : t_pwr

  task automatic t_soft();
    int w = 0;
    @(posedge clk_sys);
    gpio_in <= 2'b01;
    cyc(3);
    check("INT_OE", 1, int_oe);
    wr_ctrl(8'h01);
    check("MODE", PEMC_ST_RESET, mode);
    check("TIMER_RUN", 1, timer_run);
    check("INT_OE", 0, int_oe);
    check("INT_LINE", 1, int_line);
    @(posedge clk_sys);
    pg_mask <= 8'h00;
    supply_low <= 8'h08;
    adc_evt <= pemc_adc_t'(3'h4);
    cyc(4);
    check("PG_PEND", 0, pg_pend);
    check("MODE", PEMC_ST_RESET, mode);
    @(posedge clk_sys);
    supply_low <= 8'h00;
    pg_mask <= 8'hFF;
    adc_evt <= '0;
    while (host_rst_n !== 1'b1 && w < 60) begin
      cyc(1);
      w++;
    end
    check("PULSE_LONG", 1, w + 6 > TCAP);
    ev_hit(EV_GPIO1, 1'b1);
  endtask : t_soft

  task automatic t_pg();
    @(posedge clk_sys);
    pg_mask <= 8'hFB;
    supply_low <= 8'h05;
    cyc(3);
    check("PG_FAULT_STAT", 8'h01, pg_stat);
    check("MODE", PEMC_ST_NORMAL, mode);
    check("INT_OE", 0, int_oe);
    @(posedge clk_sys);
    boost_ovp <= 1'b1;
    cyc(3);
    check("MODE", PEMC_ST_RESET, mode);
    wait_mode(PEMC_ST_SLEEP, 40);
    check("RESET_OUT", 0, host_rst_n);
    check("PG_PEND", 8'h05, pg_pend);
    @(posedge clk_sys);
    boost_ovp <= 1'b0;
    supply_low <= 8'h00;
    pwr_cycle(1'b0);
    check("INT_OE", 1, int_oe);
    @(posedge clk_sys);
    pg_clear <= 8'hFF;
    @(posedge clk_sys);
    pg_clear <= 8'h00;
    cyc(2);
    check("PG_PEND", 0, pg_pend);
    check("INT_OE", 0, int_oe);
  endtask : t_pg

  task automatic t_hw();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      hw_rst_n <= 1'b0;
      cyc(k ? DGL + 3 : DGL - 2);
      check("MODE", k ? PEMC_ST_HWHOLD : PEMC_ST_NORMAL, mode);
      check("RESET_OUT", !k, host_rst_n);
      @(posedge clk_sys);
      hw_rst_n <= 1'b1;
    end
    cyc(3);
    check("MODE", PEMC_ST_RESET, mode);
    wait_mode(PEMC_ST_NORMAL, 60);
  endtask : t_hw

  task automatic t_sleep();
    wr_ctrl(8'h40);
    cyc(1);
    check("MODE", PEMC_ST_SLEEP, mode);
    check("SLEEP_THERMAL", 0, sleep_th);
    check("RESET_OUT", 0, host_rst_n);
    pwr_cycle(1'b0);
  endtask : t_sleep

  task automatic t_thermal();
    @(posedge clk_sys);
    evt_mask <= 14'h3FFF;
    group_mask <= 4'hF;
    thermal <= 1'b1;
    cyc(3);
    check("MODE", PEMC_ST_SLEEP, mode);
    check("SLEEP_THERMAL", 1, sleep_th);
    @(posedge clk_sys);
    thermal <= 1'b0;
    in_pwr <= 1'b0;
    cyc(3);
    @(posedge clk_sys);
    in_pwr <= 1'b1;
    cyc(4);
    check("MODE", PEMC_ST_SLEEP, mode);
    pwr_cycle(1'b1);
  endtask : t_thermal

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    {boost_ovp, thermal, rst_ctrl_wr} = 3'h0;
    {hw_rst_n, in_pwr, bat_pwr} = 3'h7;
    supply_low = 8'h00;
    pg_mask = 8'hFF;
    pg_clear = 8'h00;
    gpio_in = 2'b00;
    gpio_cfg = 2'b00;
    adc_evt = '0;
    pwr_status = STATUS_RST;
    evt_mask = '0;
    evt_clear = '0;
    group_mask = '0;
    rst_ctrl = 8'h00;
    repeat (19) @(posedge clk_sys);
    t_reset();
    t_sys();
    t_adc();
    t_pwr();
    t_soft();
    t_pg();
    t_hw();
    t_sleep();
    t_thermal();
    tally_and_finish();
  end
endmodule : pemc_top_test
`default_nettype wire
